// ==== common/homing_pkg.sv ====
// package: register map, field layout and timing constants of the reference-search sequencer
package homing_pkg;

  // register byte offsets (one aligned 32-bit word each)
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_METHOD = 8'h08;
  localparam logic [7:0] REG_OFFSET = 8'h0C;
  localparam logic [7:0] REG_SWITCH_SPEED = 8'h10;
  localparam logic [7:0] REG_INDEX_SPEED = 8'h14;
  localparam logic [7:0] REG_ACCEL = 8'h18;
  localparam logic [7:0] REG_STALL_CURRENT = 8'h1C;
  localparam logic [7:0] REG_STALL_DWELL = 8'h20;
  localparam logic [7:0] REG_SWITCH_ENABLE = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_ZERO = 8'h2C;

  // field positions
  localparam int CTRL_START_BIT = 4;
  localparam int STAT_TARGET_BIT = 10;
  localparam int STAT_HOMED_BIT = 12;
  localparam int STAT_ERROR_BIT = 13;
  localparam int EN_NEG_BIT = 0;
  localparam int EN_POS_BIT = 1;
  localparam int EN_HOME_BIT = 2;

  // mode and reset values
  localparam logic [7:0] MODE_HOMING = 8'h06;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] METHOD_RESET = 8'h23;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [15:0] DWELL_RESET = 16'h0064;
  localparam logic [2:0] ENABLE_RESET = 3'h0;

  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int SAMPLE_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SWITCH = 3'b001,
    ST_INDEX = 3'b010,
    ST_DWELL = 3'b011,
    ST_STOP = 3'b100,
    ST_DONE = 3'b101
  } seq_state_t;

  // speed command to the motion layer
  typedef struct packed {
    logic active;
    logic dir_pos;
    logic [31:0] speed;
    logic [31:0] accel;
  } drive_cmd_t;

endpackage : homing_pkg

// ==== hw/axis_reference_search.sv ====
// design: reference-search (homing) sequencer with a classic Wishbone register slave
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

// Operation
// - control bit 4 high starts search; runs until done or bit drops
// - status 13/12/10: 000 run, 001 stopped, 010 homed-not-now, 011 done
// - error: 100 while motor turns, 101 at standstill
// - bit 12 set after first completed search since restart
// - bit 12 cleared during later searches, and after error until completion
// - zero point equals captured position minus programmed offset
// - method number picks reference event and starting direction
// - methods 1-14, 33, 34 use index; 17-30 same profiles without
// - negative method uses block detection; only listed values valid
// - block search accepted only in closed-loop control
// - block detected when motor current exceeds threshold
// - after block, keep driving for the programmed millisecond dwell; -7 to -14 and -23 to -30 reverse at once instead
// - switch speed seeking switches, index speed seeking index, one accel
// - method 1 negative limit then index; 2 positive limit then index
// - 3/4 home switch left edge plus index; 5/6 right edge
// - 7-14 home switch plus index; 7-10 positive, 11-14 negative limit
// - 17 negative limit, 18 positive limit, no index
// - 19/20 left home edge, 21/22 right edge, no index
// - 23-30 home switch, no index; 23-26 positive, 27-30 negative limit
// - 33/34 reference the next index pulse only
// - 35 takes current position; needs no operation-enabled state
// - switch inputs used only when their enable bits 0-2 are set
// - switches sampled every millisecond; shorter glitches ignored
module axis_reference_search
  import homing_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int MS_COUNT = MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [DATA_W-1:0] dat_i,
  output logic [DATA_W-1:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // axis feedback
  input wire logic neg_limit,
  input wire logic pos_limit,
  input wire logic home_switch,
  input wire logic index_pulse,
  input wire logic [31:0] position,
  input wire logic [15:0] motor_current,
  input wire logic standstill,
  input wire logic closed_loop,
  input wire logic op_enabled,
  // motion command and zero point
  output drive_cmd_t drive_cmd,
  output logic [31:0] zero_position,
  output logic zero_load
);

  logic [31:0] control_q, offset_q, sw_speed_q, ix_speed_q, accel_q;
  logic [7:0] mode_q, method_q;
  logic [15:0] stall_cur_q, dwell_q;
  logic [2:0] enable_q;
  seq_state_t state_q;
  logic homed_q, error_q, done_q, ran_q;
  logic ack_q;
  logic [DATA_W-1:0] rdata_q;
  logic err_q;

  // --- bus slave: one wait state then ack, or err for unmapped addresses; unmapped reads zero, writes dropped
  logic req, mapped;
  assign req = cyc_i & stb_i & ~ack_q & ~err_q;
  always_comb begin
    case (adr_i)
      REG_CONTROL, REG_MODE, REG_METHOD, REG_OFFSET, REG_SWITCH_SPEED, REG_INDEX_SPEED,
      REG_ACCEL, REG_STALL_CURRENT, REG_STALL_DWELL, REG_SWITCH_ENABLE, REG_STATUS,
      REG_ZERO: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  logic wr;
  assign wr = req & we_i & mapped;

  // half-width registers reuse the byte-lane merge through a full-width copy
  logic [31:0] stall_wr, dwell_wr;
  assign stall_wr = merge({16'h0000, stall_cur_q}, dat_i, sel_i);
  assign dwell_wr = merge({16'h0000, dwell_q}, dat_i, sel_i);

  always_ff @(posedge clk) begin
    if (rst) begin
      control_q <= WORD_RESET;
      mode_q <= MODE_RESET;
      method_q <= METHOD_RESET;
      offset_q <= WORD_RESET;
      sw_speed_q <= WORD_RESET;
      ix_speed_q <= WORD_RESET;
      accel_q <= WORD_RESET;
      stall_cur_q <= WORD_RESET[15:0];
      dwell_q <= DWELL_RESET;
      enable_q <= ENABLE_RESET;
    end else if (wr) begin
      case (adr_i)
        REG_CONTROL: control_q <= merge(control_q, dat_i, sel_i);
        REG_MODE: if (sel_i[0]) mode_q <= dat_i[7:0];
        REG_METHOD: if (sel_i[0]) method_q <= dat_i[7:0];
        REG_OFFSET: offset_q <= merge(offset_q, dat_i, sel_i);
        REG_SWITCH_SPEED: sw_speed_q <= merge(sw_speed_q, dat_i, sel_i);
        REG_INDEX_SPEED: ix_speed_q <= merge(ix_speed_q, dat_i, sel_i);
        REG_ACCEL: accel_q <= merge(accel_q, dat_i, sel_i);
        REG_STALL_CURRENT: stall_cur_q <= stall_wr[15:0];
        REG_STALL_DWELL: dwell_q <= dwell_wr[15:0];
        REG_SWITCH_ENABLE: if (sel_i[0]) enable_q <= dat_i[2:0];
        default: ;
      endcase
    end
  end

  logic [31:0] status_w;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= req & mapped;
      err_q <= req & ~mapped;
      if (req & ~we_i) begin
        case (adr_i)
          REG_CONTROL: rdata_q <= control_q;
          REG_MODE: rdata_q <= {24'h000000, mode_q};
          REG_METHOD: rdata_q <= {24'h000000, method_q};
          REG_OFFSET: rdata_q <= offset_q;
          REG_SWITCH_SPEED: rdata_q <= sw_speed_q;
          REG_INDEX_SPEED: rdata_q <= ix_speed_q;
          REG_ACCEL: rdata_q <= accel_q;
          REG_STALL_CURRENT: rdata_q <= {16'h0000, stall_cur_q};
          REG_STALL_DWELL: rdata_q <= {16'h0000, dwell_q};
          REG_SWITCH_ENABLE: rdata_q <= {29'h00000000, enable_q};
          REG_STATUS: rdata_q <= status_w;
          REG_ZERO: rdata_q <= zero_position;
          default: rdata_q <= '0;
        endcase
      end
    end
  end
  assign ack_o = ack_q;
  assign err_o = err_q;
  assign dat_o = rdata_q;

  // --- switch sampling: one sample per millisecond; a level must be seen twice
  logic [31:0] ms_cnt_q;
  logic tick;
  logic [2:0] raw, smp_q, sw_q;
  assign tick = (ms_cnt_q == 32'(MS_COUNT - 1));
  assign raw = {home_switch, pos_limit, neg_limit};

  always_ff @(posedge clk) begin
    if (rst) ms_cnt_q <= '0;
    else ms_cnt_q <= tick ? '0 : ms_cnt_q + 32'h1;
  end

  generate
    for (genvar i = 0; i < 3; i++) begin : g_sw
      always_ff @(posedge clk) begin
        if (rst) begin
          smp_q[i] <= 1'b0;
          sw_q[i] <= 1'b0;
        end else if (tick) begin
          smp_q[i] <= raw[i];
          // a change shorter than one sample period never reaches sw_q
          if (smp_q[i] == raw[i]) sw_q[i] <= raw[i] & enable_q[i];
        end
      end
    end
  endgenerate

  logic neg_sw, pos_sw, home_sw, home_prev_q;
  assign neg_sw = sw_q[EN_NEG_BIT];
  assign pos_sw = sw_q[EN_POS_BIT];
  assign home_sw = sw_q[EN_HOME_BIT];

  // --- method decode
  logic signed [7:0] m_s;
  logic [7:0] mag, base;
  logic block, use_index, valid, start_pos, right_edge, index_only, here;
  logic [1:0] kind; // 0 limit, 1 home edge, 2 home with limit
  assign m_s = method_q;
  assign block = m_s < 0;
  assign mag = block ? 8'(-m_s) : method_q;
  assign base = (mag >= 8'd17 && mag <= 8'd30) ? mag - 8'd16 : mag;

  always_comb begin
    use_index = (mag <= 8'd14) || mag == 8'd33 || mag == 8'd34;
    index_only = mag == 8'd33 || mag == 8'd34;
    here = mag == 8'd35 && !block;
    if (block) valid = mag == 8'd1 || mag == 8'd2 || (mag >= 8'd7 && mag <= 8'd14) ||
                       mag == 8'd17 || mag == 8'd18 || (mag >= 8'd23 && mag <= 8'd30);
    else valid = (mag >= 8'd1 && mag <= 8'd30 && !(mag == 8'd15 || mag == 8'd16)) ||
                 (mag >= 8'd33 && mag <= 8'd35);
    kind = 2'd0;
    start_pos = 1'b0;
    right_edge = 1'b0;
    case (base)
      8'd1: start_pos = 1'b0;
      8'd2: start_pos = 1'b1;
      8'd3, 8'd4: begin
        kind = 2'd1;
        start_pos = base == 8'd3;
      end
      8'd5, 8'd6: begin
        kind = 2'd1;
        right_edge = 1'b1;
        start_pos = base == 8'd6;
      end
      default: begin
        kind = 2'd2;
        start_pos = base <= 8'd10;
        right_edge = base == 8'd8 || base == 8'd10 || base == 8'd12 || base == 8'd14;
      end
    endcase
    if (index_only) start_pos = mag == 8'd34;
  end

  // --- sequencer
  logic run, go;
  logic dir_q, stalled;
  logic [15:0] ms_left_q;
  logic [31:0] capture_q;
  assign run = control_q[CTRL_START_BIT] && mode_q == MODE_HOMING;
  assign stalled = motor_current > stall_cur_q;

  logic limit_hit, edge_hit;
  assign limit_hit = block ? stalled : (dir_q ? pos_sw : neg_sw);
  assign edge_hit = home_sw != home_prev_q && (right_edge ? !home_sw : home_sw);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      dir_q <= 1'b0;
      ms_left_q <= '0;
      capture_q <= '0;
      home_prev_q <= 1'b0;
      error_q <= 1'b0;
      done_q <= 1'b0;
      ran_q <= 1'b0;
      zero_load <= 1'b0;
    end else begin
      home_prev_q <= home_sw;
      zero_load <= 1'b0;
      case (state_q)
        ST_IDLE, ST_DONE: begin
          if (state_q == ST_DONE && !run) state_q <= ST_IDLE;
          if (run && state_q == ST_IDLE) begin
            done_q <= 1'b0;
            error_q <= 1'b0;
            ran_q <= 1'b1;
            dir_q <= start_pos;
            if (!valid || (block && !closed_loop) || (!here && !op_enabled)) begin
              error_q <= 1'b1;
              state_q <= ST_STOP;
            end else if (here) begin
              capture_q <= position;
              state_q <= ST_DONE;
              done_q <= 1'b1;
              zero_load <= 1'b1;
            end else if (index_only) begin
              state_q <= ST_INDEX;
            end else begin
              state_q <= ST_SWITCH;
            end
          end
        end
        ST_SWITCH: begin
          if (!run) state_q <= ST_STOP;
          else if (limit_hit && kind == 2'd0) begin
            if (block) begin
              ms_left_q <= dwell_q;
              state_q <= ST_DWELL;
            end else if (use_index) begin
              dir_q <= ~dir_q;
              state_q <= ST_INDEX;
            end else begin
              capture_q <= position;
              zero_load <= 1'b1;
              done_q <= 1'b1;
              state_q <= ST_DONE;
            end
          end else if (limit_hit) begin
            dir_q <= ~dir_q; // reverse off the end stop, keep seeking the home edge
          end else if (kind != 2'd0 && edge_hit) begin
            if (use_index) state_q <= ST_INDEX;
            else begin
              capture_q <= position;
              zero_load <= 1'b1;
              done_q <= 1'b1;
              state_q <= ST_DONE;
            end
          end
        end
        ST_DWELL: begin
          if (!run) state_q <= ST_STOP;
          else if (tick) begin
            if (ms_left_q == 16'h0000) begin
              dir_q <= ~dir_q;
              if (use_index) state_q <= ST_INDEX;
              else begin
                capture_q <= position;
                zero_load <= 1'b1;
                done_q <= 1'b1;
                state_q <= ST_DONE;
              end
            end else ms_left_q <= ms_left_q - 16'h0001;
          end
        end
        ST_INDEX: begin
          if (!run) state_q <= ST_STOP;
          else if (index_pulse) begin
            capture_q <= position;
            zero_load <= 1'b1;
            done_q <= 1'b1;
            state_q <= ST_DONE;
          end
        end
        ST_STOP: if (standstill && !run) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // homed flag: set on completion, dropped while running or after an error
  always_ff @(posedge clk) begin
    if (rst) homed_q <= 1'b0;
    else if (zero_load) homed_q <= 1'b1;
    else if (go || error_q) homed_q <= 1'b0;
  end
  assign go = state_q == ST_SWITCH || state_q == ST_INDEX || state_q == ST_DWELL;

  // zero point sits offset away from the captured reference
  assign zero_position = capture_q - offset_q;

  always_comb begin
    status_w = '0;
    if (error_q) begin
      status_w[STAT_ERROR_BIT] = 1'b1;
      status_w[STAT_TARGET_BIT] = standstill;
    end else if (go) begin
      status_w = '0;
    end else begin
      status_w[STAT_HOMED_BIT] = homed_q;
      status_w[STAT_TARGET_BIT] = done_q ? 1'b1 : !ran_q || !homed_q;
      if (ran_q && homed_q && !done_q) status_w[STAT_TARGET_BIT] = 1'b0;
    end
  end

  always_comb begin
    drive_cmd.active = go;
    drive_cmd.dir_pos = dir_q;
    drive_cmd.speed = state_q == ST_INDEX ? ix_speed_q : sw_speed_q;
    drive_cmd.accel = accel_q;
    if (!go) drive_cmd.speed = '0;
  end

endmodule : axis_reference_search

// ==== test/axis_reference_search_assertions.sv ====
// checker: bus handshake, pulse and status-code properties of the sequencer
`timescale 1ns/100ps
module axis_reference_search_assertions
  import homing_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // motion
  input wire drive_cmd_t drive_cmd,
  input wire logic zero_load
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic req;
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  a_answer_next: assert property (req |=> ack_o || err_o)
    else $error("bus request not answered in the next cycle");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_answer_excl: assert property (!(ack_o && err_o))
    else $error("ack and err raised together");
  a_unmapped_err: assert property (req && adr_i > REG_ZERO |=> err_o && !ack_o)
    else $error("unmapped address not refused");
  a_answer_cause: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i))
    else $error("answer without a request");
  a_status_code: assert property (
    ack_o && !we_i && adr_i == REG_STATUS |-> (dat_o & ~32'h0000_3400) == 32'h0
      && !(dat_o[13] && dat_o[12])) else $error("illegal status code");
  a_idle_speed: assert property (!drive_cmd.active |-> drive_cmd.speed == 32'h0)
    else $error("speed commanded while idle");
  a_zero_pulse: assert property (zero_load |=> !zero_load)
    else $error("zero load longer than one cycle");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !ack_o && !err_o && !drive_cmd.active) else $error("outputs active after reset");
  c_zero: cover property (zero_load);
  c_err: cover property (err_o);
  c_neg_seek: cover property (drive_cmd.active && !drive_cmd.dir_pos);
endmodule : axis_reference_search_assertions

// ==== test/axis_partner.sv ====
// partner: axis model with limit and home switches and an encoder index
`timescale 1ns/100ps
module axis_partner
  import homing_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command from the sequencer
  input wire drive_cmd_t drive_cmd,
  // axis feedback
  output logic neg_limit,
  output logic pos_limit,
  output logic home_switch,
  output logic index_pulse,
  output logic [31:0] position,
  output logic standstill
);
  logic [2:0] step_q;
  logic [31:0] pos_q;
  // one count per eight clocks so switch edges outlast the millisecond filter
  always_ff @(posedge clk) begin
    if (rst) begin
      step_q <= 3'h0;
      pos_q <= 32'h0000_0100;
    end else if (drive_cmd.active) begin
      step_q <= step_q + 3'h1;
      if (step_q == 3'h7) begin
        pos_q <= drive_cmd.dir_pos ? pos_q + 32'h1 : pos_q - 32'h1;
      end
    end
  end
  assign position = pos_q;
  assign standstill = !drive_cmd.active;
  // limit switches sit in front of the stops, home switch between them
  // travel past a limit switch is never blocked
  assign neg_limit = pos_q <= 32'h0000_00E0;
  assign pos_limit = pos_q >= 32'h0000_0120;
  assign home_switch = pos_q >= 32'h0000_0108 && pos_q <= 32'h0000_0110;
  assign index_pulse = drive_cmd.active && pos_q[3:0] == 4'h8 && step_q == 3'h0;
endmodule : axis_partner

// ==== test/test_axis_reference_search.sv ====
// testbench: register-level reference-search scenarios against the axis model
`timescale 1ns/100ps
module test_axis_reference_search
  import homing_pkg::*;
;
  logic clk, rst, cyc, stb, we, cl, oe, ack_o, err_o, nl, pl, hs, ip, still, zl, last_err;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [15:0] cur;
  logic [31:0] dat, dat_o, position, zp, zlast;
  drive_cmd_t dc;
  int mismatches, checks_done, zcount, zc0, wait_n;
  always #2.5 clk = ~clk;
  axis_reference_search #(.MS_COUNT(20)) dut_u (
    .clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .neg_limit(nl),
    .pos_limit(pl), .home_switch(hs), .index_pulse(ip), .position(position),
    .motor_current(cur), .standstill(still), .closed_loop(cl), .op_enabled(oe),
    .drive_cmd(dc), .zero_position(zp), .zero_load(zl));
  axis_partner partner_u (
    .clk(clk), .rst(rst), .drive_cmd(dc), .neg_limit(nl), .pos_limit(pl),
    .home_switch(hs), .index_pulse(ip), .position(position), .standstill(still));
  always @(posedge clk) begin
    if (zl === 1'b1) begin
      zcount++;
      zlast = zp;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    @(posedge clk);
    while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) chk("bus answer", 32'h0, 32'h1);
    q = dat_o;
    last_err = err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  // polls until the expected value shows or the tries run out
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp, input int tries);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    for (int i = 1; i < tries && q !== exp; i++) bus(a, 1'b0, 32'h0, q);
    chk(nm, q, exp);
  endtask : rd
  task automatic start(input logic [7:0] m);
    wr(REG_CONTROL, 32'h0);
    wr(REG_METHOD, {24'h0, m});
    zc0 = zcount;
    wr(REG_CONTROL, 32'h0000_0010);
    repeat (2) @(posedge clk);
  endtask : start
  task automatic await_zero();
    int n;
    n = 0;
    while (zcount == zc0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk("zero_load count", 32'(zcount - zc0), 32'h1);
  endtask : await_zero
  task automatic wrap_up();
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #400_000;
    mismatches++;
    wrap_up();
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, oe, last_err} = 5'h0;
    cl = 1'b1;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    cur = 16'h0000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("status", REG_STATUS, 32'h0000_0400, 1);
    rd("method", REG_METHOD, 32'h0000_0023, 1);
    rd("dwell", REG_STALL_DWELL, 32'h0000_0064, 1);
    rd("unmapped", 8'h40, 32'h0, 1);
    chk("err", {31'h0, last_err}, 32'h1);
    wr(REG_MODE, {24'h0, MODE_HOMING});
    wr(REG_OFFSET, 32'h0000_0010);
    wr(REG_SWITCH_SPEED, 32'h0000_0033);
    wr(REG_INDEX_SPEED, 32'h0000_0055);
    wr(REG_ACCEL, 32'h0000_0077);
    wr(REG_SWITCH_ENABLE, 32'h0000_0007);
    start(8'h23);
    await_zero();
    chk("zero_position", zlast, position - 32'h10);
    rd("status", REG_STATUS, 32'h0000_1400, 200);
    oe <= 1'b1;
    start(8'h21);
    rd("status", REG_STATUS, 32'h0, 20);
    chk("index speed", dc.speed, 32'h55);
    await_zero();
    rd("status", REG_STATUS, 32'h0000_1400, 200);
    start(8'h11);
    chk("dir_pos", {31'h0, dc.dir_pos}, 32'h0);
    chk("switch speed", dc.speed, 32'h33);
    chk("accel", dc.accel, 32'h77);
    await_zero();
    start(8'h12);
    rd("status", REG_STATUS, 32'h0, 20);
    wr(REG_CONTROL, 32'h0);
    rd("status", REG_STATUS, 32'h0000_0400, 200);
    // block search: current at the threshold must not count as a block
    wr(REG_STALL_CURRENT, 32'h0000_0100);
    wr(REG_STALL_DWELL, 32'h0000_0002);
    start(8'hEF);
    cur <= 16'h0100;
    repeat (70) @(posedge clk);
    chk("stall at threshold", 32'(zcount - zc0), 32'h0);
    cur <= 16'h0200;
    wait_n = 0;
    while (zcount == zc0 && wait_n < 100) begin
      @(posedge clk);
      wait_n++;
    end
    cur <= 16'h0000;
    // two dwell milliseconds of 20 clocks each, plus up to one partial tick
    chk("dwell cycles", {31'h0, wait_n >= 40 && wait_n <= 64}, 32'h1);
    rd("status", REG_STATUS, 32'h0000_1400, 1);
    start(8'h13);
    await_zero();
    chk("home edge", {31'h0, zlast >= 32'hF8 && zlast <= 32'hFE}, 32'h1);
    start(8'h0F);
    rd("status", REG_STATUS, 32'h0000_2400, 200);
    cl <= 1'b0;
    start(8'hEF);
    rd("status", REG_STATUS, 32'h0000_2400, 200);
    wrap_up();
  end
endmodule : test_axis_reference_search
bind axis_reference_search axis_reference_search_assertions chk_u (
  .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .drive_cmd(drive_cmd), .zero_load(zero_load));
